/* rtl/tsq_pkg.sv */
package tsq_pkg;

  // command byte layout: class in the upper nibble, option in the lower
  localparam int CMD_W = 8;
  localparam int CLASS_LSB = 4;
  localparam int OPT_W = 4;

  // command classes
  localparam logic [3:0] CLASS_CONTROL = 4'h0;
  localparam logic [3:0] CLASS_ADD_COPY = 4'h1;

  // control-class options
  localparam logic [3:0] OPT_SD_DISABLE = 4'h2;
  localparam logic [3:0] OPT_SD_ENABLE = 4'h6;
  localparam logic [3:0] OPT_WAIT_T0 = 4'h8;
  localparam logic [3:0] OPT_WAIT_T1 = 4'h9;
  localparam logic [3:0] OPT_WAIT_SWT = 4'hB;
  localparam logic [3:0] OPT_CHSEL_C0 = 4'hC;
  localparam logic [3:0] OPT_CHSEL_C1 = 4'hD;
  localparam logic [3:0] OPT_CHSEL_LIT = 4'hE;
  localparam logic [3:0] OPT_BROADCAST = 4'hF;

  // add/copy options: add uses 0..5, copy uses 8..13 on the same targets
  localparam logic [3:0] OPT_ADD_LAST = 4'h5;
  localparam logic [3:0] OPT_COPY_FIRST = 4'h8;
  localparam logic [3:0] OPT_COPY_LAST = 4'hD;

  // limit register file indices
  localparam int NUM_LIM = 6;
  localparam logic [2:0] LIM_C0 = 3'h0;
  localparam logic [2:0] LIM_C1 = 3'h1;
  localparam logic [2:0] LIM_T0 = 3'h2;
  localparam logic [2:0] LIM_T1 = 3'h3;
  localparam logic [2:0] LIM_SD = 3'h4;
  localparam logic [2:0] LIM_LIT0 = 3'h5;

  // wait timers: timer zero, timer one, step delay
  localparam int NUM_TMR = 3;
  localparam int TMR_T0 = 0;
  localparam int TMR_T1 = 1;
  localparam int TMR_SD = 2;

  // reset values
  localparam logic [15:0] LIM_RESET = 16'h0000;
  localparam logic [5:0] CHSEL_RESET = 6'h00;
  localparam logic SD_EN_RESET = 1'b0;

  // converter channel-select width
  localparam int CHSEL_W = 6;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_WAIT_TMR,
    ST_WAIT_SWT,
    ST_WAIT_SD
  } tsq_state_e;

endpackage

/* rtl/tsq_wait_timer.sv */
`timescale 1ns/1ps
module tsq_wait_timer
  import tsq_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic start,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);

  logic run_q;
  logic run_d;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // done is a one-cycle pulse when the running count meets the limit
  assign done = run_q && (count_q == limit);

  // next count: start clears and runs, match stops
  always_comb
  begin
    run_d = run_q;
    count_d = count_q;
    if (start)
    begin
      run_d = 1'b1;
      count_d = '0;
    end
    else if (done)
      run_d = 1'b0;
    else if (run_q)
      count_d = count_q + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      run_q <= 1'b0;
      count_q <= '0;
    end
    else
    begin
      run_q <= run_d;
      count_q <= count_d;
    end
  end

endmodule // tsq_wait_timer

/* rtl/tsq_sequencer.sv */
`timescale 1ns/1ps
// Contract
// - control option 0010 turns the step delay timer off
// - control option 0110 turns the step delay timer on
// - control option 1000 starts timer zero, waits until it meets its limit
// - control option 1001 starts timer one, waits until it meets its limit
// - control option 1011 waits for a rising edge of the software trigger
// - options 1100/1101 load channel select from counter zero/one
// - option 1110 loads channel select from literal zero
// - option 1111 pulses every trigger enabled in the broadcast mask
// - add options 0000..0101 add the adjust value into the six limits
// - copy options 1000..1101 copy the hold value into the six limits
// - reserved classes and options execute as a no-operation
module tsq_sequencer
  import tsq_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int TRIG_W = 16
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic step_valid,
  input wire logic [CMD_W-1:0] step_cmd,
  output logic step_ready_q,
  input wire logic software_trigger_bit,
  input wire logic [DATA_W-1:0] adjust_value,
  input wire logic [DATA_W-1:0] hold_value,
  input wire logic [DATA_W-1:0] counter_zero,
  input wire logic [DATA_W-1:0] counter_one,
  input wire logic [TRIG_W-1:0] broadcast_trigger_enable,
  input wire logic cfg_write,
  input wire logic [2:0] cfg_index,
  input wire logic [DATA_W-1:0] cfg_data,
  output logic [NUM_LIM-1:0][DATA_W-1:0] limits_q,
  output logic [CHSEL_W-1:0] converter_channel_select_q,
  output logic [TRIG_W-1:0] trigger_out_q,
  output logic step_delay_en_q
);

  tsq_state_e state_q;
  tsq_state_e state_d;
  logic [CMD_W-1:0] cmd_q;
  logic [CMD_W-1:0] cmd_d;
  logic [1:0] tmr_sel_q;
  logic [1:0] tmr_sel_d;
  logic swt_prev_q;
  logic step_ready_d;
  logic [NUM_LIM-1:0][DATA_W-1:0] limits_d;
  logic [CHSEL_W-1:0] chsel_d;
  logic [TRIG_W-1:0] trig_d;
  logic sd_en_d;
  logic [NUM_TMR-1:0] tmr_start;
  logic [NUM_TMR-1:0] tmr_done;
  logic [NUM_TMR-1:0][DATA_W-1:0] tmr_limit;
  logic [3:0] cls;
  logic [3:0] opt;
  logic swt_rise;

  // splits the command byte into class and option
  function automatic logic [3:0] cmd_class(input logic [CMD_W-1:0] c);
    return c[CMD_W-1:CLASS_LSB];
  endfunction

  function automatic logic [3:0] cmd_option(input logic [CMD_W-1:0] c);
    return c[OPT_W-1:0];
  endfunction

  assign cls = cmd_class(cmd_q);
  assign opt = cmd_option(cmd_q);
  assign swt_rise = software_trigger_bit && !swt_prev_q;

  // limits that the three wait timers compare against
  assign tmr_limit[TMR_T0] = limits_q[LIM_T0];
  assign tmr_limit[TMR_T1] = limits_q[LIM_T1];
  assign tmr_limit[TMR_SD] = limits_q[LIM_SD];

  // one wait timer per limit-driven delay
  for (genvar i = 0; i < NUM_TMR; i++)
  begin : g_tmr
    tsq_wait_timer #(
      .WIDTH(DATA_W)
    ) u_tmr (
      .clock(clock),
      .srst(srst),
      .start(tmr_start[i]),
      .limit(tmr_limit[i]),
      .done(tmr_done[i])
    );
  end

  // step engine: fetch, execute, then the wait that the step asks for
  always_comb
  begin
    state_d = state_q;
    cmd_d = cmd_q;
    tmr_sel_d = tmr_sel_q;
    limits_d = limits_q;
    chsel_d = converter_channel_select_q;
    trig_d = '0;
    sd_en_d = step_delay_en_q;
    tmr_start = '0;
    // software loads a limit; a step update in the same cycle wins
    if (cfg_write && (cfg_index < 3'(NUM_LIM)))
      limits_d[cfg_index] = cfg_data;
    unique case (state_q)
      ST_IDLE:
      begin
        if (step_valid)
        begin
          cmd_d = step_cmd;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        state_d = ST_IDLE;
        if (cls == CLASS_CONTROL)
        begin
          unique case (opt)
            OPT_SD_DISABLE: sd_en_d = 1'b0;
            OPT_SD_ENABLE: sd_en_d = 1'b1;
            OPT_WAIT_T0:
            begin
              tmr_start[TMR_T0] = 1'b1;
              tmr_sel_d = 2'(TMR_T0);
              state_d = ST_WAIT_TMR;
            end
            OPT_WAIT_T1:
            begin
              tmr_start[TMR_T1] = 1'b1;
              tmr_sel_d = 2'(TMR_T1);
              state_d = ST_WAIT_TMR;
            end
            OPT_WAIT_SWT: state_d = ST_WAIT_SWT;
            OPT_CHSEL_C0: chsel_d = counter_zero[CHSEL_W-1:0];
            OPT_CHSEL_C1: chsel_d = counter_one[CHSEL_W-1:0];
            OPT_CHSEL_LIT:
              chsel_d = limits_q[LIM_LIT0][CHSEL_W-1:0];
            OPT_BROADCAST: trig_d = broadcast_trigger_enable;
            default: ; // reserved option: no effect
          endcase
        end
        else if (cls == CLASS_ADD_COPY)
        begin
          if (opt <= OPT_ADD_LAST)
            limits_d[opt[2:0]] = limits_q[opt[2:0]] + adjust_value;
          else if (opt >= OPT_COPY_FIRST && opt <= OPT_COPY_LAST)
            limits_d[3'(opt - OPT_COPY_FIRST)] = hold_value;
        end
        // other classes fall through as a no-operation
        if (state_d == ST_IDLE && sd_en_d)
        begin
          tmr_start[TMR_SD] = 1'b1;
          state_d = ST_WAIT_SD;
        end
      end
      ST_WAIT_TMR:
      begin
        if (tmr_done[tmr_sel_q])
        begin
          if (step_delay_en_q)
          begin
            tmr_start[TMR_SD] = 1'b1;
            state_d = ST_WAIT_SD;
          end
          else
            state_d = ST_IDLE;
        end
      end
      ST_WAIT_SWT:
      begin
        if (swt_rise)
        begin
          if (step_delay_en_q)
          begin
            tmr_start[TMR_SD] = 1'b1;
            state_d = ST_WAIT_SD;
          end
          else
            state_d = ST_IDLE;
        end
      end
      ST_WAIT_SD:
      begin
        if (tmr_done[TMR_SD])
          state_d = ST_IDLE;
      end
    endcase
    step_ready_d = (state_d == ST_IDLE);
  end

  // registers of the step engine
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      tmr_sel_q <= '0;
      swt_prev_q <= 1'b0;
      step_ready_q <= 1'b0;
      limits_q <= {NUM_LIM{LIM_RESET}};
      converter_channel_select_q <= CHSEL_RESET;
      trigger_out_q <= '0;
      step_delay_en_q <= SD_EN_RESET;
    end
    else
    begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      tmr_sel_q <= tmr_sel_d;
      swt_prev_q <= software_trigger_bit;
      step_ready_q <= step_ready_d;
      limits_q <= limits_d;
      converter_channel_select_q <= chsel_d;
      trigger_out_q <= trig_d;
      step_delay_en_q <= sd_en_d;
    end
  end

  // checks on the step engine
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence s_exec_ctrl(logic [3:0] o);
    state_q == ST_EXEC && cls == CLASS_CONTROL && opt == o;
  endsequence

  sequence s_exec_addcopy;
    state_q == ST_EXEC && cls == CLASS_ADD_COPY;
  endsequence

  a_sd_off: assert property (s_exec_ctrl(OPT_SD_DISABLE) |=>
    !step_delay_en_q && state_q == ST_IDLE)
    else $error("step delay not disabled");

  a_sd_on: assert property (s_exec_ctrl(OPT_SD_ENABLE) |=>
    step_delay_en_q && state_q == ST_WAIT_SD)
    else $error("step delay not enabled");

  a_t0_wait: assert property (s_exec_ctrl(OPT_WAIT_T0) |=>
    state_q == ST_WAIT_TMR ##0 (!step_ready_q [*1]))
    else $error("timer zero wait not entered");

  a_t1_release: assert property (s_exec_ctrl(OPT_WAIT_T1)
    ##0 (limits_q[LIM_T1] == 16'h0003 && !cfg_write)
    |=> state_q == ST_WAIT_TMR [*4] ##1 state_q != ST_WAIT_TMR)
    else $error("timer one wait length wrong");

  a_swt_hold: assert property (state_q == ST_WAIT_SWT && !swt_rise
    |=> state_q == ST_WAIT_SWT)
    else $error("software trigger wait released without edge");

  a_chsel_cnt: assert property (s_exec_ctrl(OPT_CHSEL_C1) |=>
    converter_channel_select_q == $past(counter_one[CHSEL_W-1:0]))
    else $error("channel select not loaded from counter one");

  a_chsel_lit: assert property (s_exec_ctrl(OPT_CHSEL_LIT) |=>
    converter_channel_select_q == $past(limits_q[LIM_LIT0][CHSEL_W-1:0]))
    else $error("channel select not loaded from literal");

  a_bcast_pulse: assert property (s_exec_ctrl(OPT_BROADCAST) |=>
    trigger_out_q == $past(broadcast_trigger_enable) ##1 trigger_out_q == '0)
    else $error("broadcast triggers wrong");

  a_add_limit: assert property (s_exec_addcopy and opt == 4'h2
    |=> limits_q[LIM_T0] == $past(limits_q[LIM_T0] + adjust_value))
    else $error("adjust not added to timer zero limit");

  a_copy_limit: assert property (s_exec_addcopy and opt == 4'hD
    |=> limits_q[LIM_LIT0] == $past(hold_value))
    else $error("hold not copied to literal zero");

  a_nop_quiet: assert property (state_q == ST_EXEC
    && cls != CLASS_CONTROL && cls != CLASS_ADD_COPY && !cfg_write
    |=> $stable(limits_q) && $stable(converter_channel_select_q)
    && trigger_out_q == '0 && $stable(step_delay_en_q))
    else $error("reserved command changed state");

  a_sd_block: assert property (state_q == ST_WAIT_SD |->
    !step_ready_q)
    else $error("fetch allowed during step delay");

endmodule // tsq_sequencer

/* testbench/tsq_trig_sink.sv */
`timescale 1ns/1ps
// stands in for the converter and the peripherals that take triggers
module tsq_trig_sink
#(
  parameter int TRIG_W = 16
)
(
  input wire logic clock,
  input wire logic [TRIG_W-1:0] trig,
  output logic [TRIG_W-1:0] seen_q,
  output int pulses_q
);
  // nothing is seen before the first trigger arrives
  initial
  begin
    seen_q = '0;
    pulses_q = 0;
  end
  // keep the last trigger set and count the cycles any trigger is high
  always @(posedge clock)
  begin
    if (trig != '0)
    begin
      seen_q <= trig;
      pulses_q <= pulses_q + 1;
    end
  end
endmodule // tsq_trig_sink

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import tsq_pkg::*;
  logic clock = 0, srst = 1, step_valid = 0, software_trigger_bit = 0;
  logic cfg_write = 0, step_ready_q, step_delay_en_q;
  logic [7:0] step_cmd = '0;
  logic [2:0] cfg_index = '0;
  logic [15:0] adjust_value = '0, hold_value = '0, cfg_data = '0;
  logic [15:0] counter_zero = '0, counter_one = '0;
  logic [15:0] broadcast_trigger_enable = '0, trigger_out_q, seen;
  logic [5:0][15:0] limits_q, exp_lim = '0;
  logic [5:0] converter_channel_select_q, exp_ch = '0;
  logic exp_en = 0;
  int fail_count = 0, comparisons = 0, lat, k, s, pulses, p0;
  localparam logic [7:0] NOPS [11] = '{8'h00, 8'h01, 8'h03, 8'h04,
    8'h05, 8'h07, 8'h0A, 8'h16, 8'h17, 8'h1E, 8'h1F};

  tsq_sequencer dut (.clock, .srst, .step_valid, .step_cmd, .step_ready_q,
    .software_trigger_bit, .adjust_value, .hold_value, .counter_zero,
    .counter_one, .broadcast_trigger_enable, .cfg_write, .cfg_index,
    .cfg_data, .limits_q, .converter_channel_select_q, .trigger_out_q,
    .step_delay_en_q);
  tsq_trig_sink sink (.clock, .trig(trigger_out_q), .seen_q(seen),
    .pulses_q(pulses));

  // free-running 250 MHz clock
  initial
  begin
    forever #2 clock = ~clock;
  end

  // counts and verdict, the single place the run ends
  task wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // wait at falling edges for ready, counting edges in lat
  task wait_ready;
    while (step_ready_q !== 1'b1)
    begin
      @(negedge clock);
      lat++;
      if (lat > 400)
      begin
        fail_count++;
        $display("Error step_ready expected 1 seen %0h", step_ready_q);
        wrap_up();
      end
    end
  endtask

  // offer one command byte; it is taken at the next rising edge
  task issue(input logic [7:0] cmd);
    step_valid = 1'b1;
    step_cmd = cmd;
    @(negedge clock);
    step_valid = 1'b0;
    lat = 1;
  endtask

  task step(input logic [7:0] cmd);
    issue(cmd);
    wait_ready();
  endtask

  // one-cycle load of a limit register while the engine is idle
  task cfg(input logic [2:0] idx, input logic [15:0] v);
    cfg_write = 1'b1;
    cfg_index = idx;
    cfg_data = v;
    @(negedge clock);
    cfg_write = 1'b0;
    // let one edge pass so a following load never re-raises the strobe
    @(negedge clock);
    if (idx < 3'h6)
      exp_lim[idx] = v;
  endtask

  task check_all;
    `CHK("limits", exp_lim, limits_q)
    `CHK("chsel", exp_ch, converter_channel_select_q)
    `CHK("sd_en", exp_en, step_delay_en_q)
  endtask

  // main sequence
  initial
  begin
    void'($urandom(32'h4419));
    repeat (5) @(negedge clock);
    srst = 1'b0;
    lat = 0;
    wait_ready();
    for (k = 0; k < 12; k++)
      cfg(3'($urandom), 16'($urandom));
    check_all();
    // add then copy into every limit, wrapping sums included
    for (k = 0; k < 12; k++)
    begin
      adjust_value = (k == 0) ? 16'hFFFF : 16'($urandom);
      hold_value = 16'($urandom);
      step((k < 6) ? 8'(16 + k) : 8'(18 + k));
      if (k < 6)
        exp_lim[k] = exp_lim[k] + adjust_value;
      else
        exp_lim[k - 6] = hold_value;
      `CHK("latency", 2, lat)
      check_all();
    end
    // timer waits: limit zero first, then timer one at a limit of three
    for (k = 0; k < 4; k++)
    begin
      s = (k < 2) ? 0 : (k == 3) ? 3 : $urandom_range(9);
      cfg(3'(2 + k % 2), 16'(s));
      step(8'(8 + k % 2));
      `CHK("timer wait", 3 + s, lat)
    end
    // channel select from both counters and literal zero
    for (k = 0; k < 3; k++)
    begin
      counter_zero = 16'($urandom);
      counter_one = 16'($urandom);
      step(8'(12 + k));
      exp_ch = (k == 0) ? counter_zero[5:0] :
        (k == 1) ? counter_one[5:0] : exp_lim[5][5:0];
      check_all();
    end
    // broadcast: every enabled trigger for exactly one cycle
    for (k = 0; k < 3; k++)
    begin
      broadcast_trigger_enable = (k == 0) ? 16'hFFFF :
        16'($urandom) | 16'h0001;
      p0 = pulses;
      step(8'h0F);
      `CHK("trigger", broadcast_trigger_enable, trigger_out_q)
      @(negedge clock);
      `CHK("trigger end", 16'h0000, trigger_out_q)
      `CHK("sink", broadcast_trigger_enable, seen)
      `CHK("pulses", p0 + 1, pulses)
    end
    // reserved codes change nothing and fire nothing
    p0 = pulses;
    for (k = 0; k < 15; k++)
    begin
      adjust_value = 16'($urandom);
      hold_value = 16'($urandom);
      step((k < 11) ? NOPS[k] : 8'($urandom_range(255, 32)));
      `CHK("nop latency", 2, lat)
      check_all();
    end
    `CHK("nop pulses", p0, pulses)
    // software trigger: a held high level does not release, a rise does
    software_trigger_bit = 1'b1;
    issue(8'h0B);
    repeat (4) @(negedge clock);
    `CHK("swt hold", 1'b0, step_ready_q)
    software_trigger_bit = 1'b0;
    @(negedge clock);
    `CHK("swt low", 1'b0, step_ready_q)
    software_trigger_bit = 1'b1;
    lat = 0;
    wait_ready();
    `CHK("swt release", 1, lat)
    // step delay on, applied after steps, then off again
    s = $urandom_range(4, 1);
    cfg(3'h4, 16'(s));
    step(8'h06);
    exp_en = 1'b1;
    `CHK("sd enable", s + 3, lat)
    step(8'h20);
    `CHK("sd step", s + 3, lat)
    step(8'h02);
    exp_en = 1'b0;
    `CHK("sd disable", 2, lat)
    check_all();
    wrap_up();
  end
endmodule // tb_top
